// ---- design/pipelined_burst_sram_port.sv ----
// Purpose: synchronous host port of a pipelined burst memory
// Assumes: host logic shares clock_in; sleep, output enable and
//          order strap are asynchronous and are synchronised here
// Notes:   writes pass an 8-word queue before the array
// Behaviour
// - Either strobe low with all selects active captures the address.
// - Two-bit wrapping counter loads low address bits, then walks the burst.
// - Advance low at an edge during a burst steps the counter.
// - Both strobes low: only processor strobe counts, unless select one high.
// - Processor strobe is ignored while select one is high.
// - Selected when one and three low, two high; sampled on loads only.
// - Byte selects are active low and count only when qualified.
// - Global write low writes all lanes regardless of byte controls.
// - Output enable low drives data pins; high releases them.
// - Read from deselected state keeps outputs off for the first cycle.
// - Data registered at edges; read data follows one edge later.
// - Strobe, selects, global write and qualify high start a read.
// - Back-to-back single reads accepted on consecutive edges.
// - A deselecting strobe releases the outputs at that edge.
// - Order strap low gives linear order, high gives interleaved.
// - Sleep high enters a quiet state that keeps stored data.
// - Processor write first edge loads address, ignores write and advance.
// - Processor write lands on second edge with global or byte lanes.
// - Linear adds modulo four; interleaved applies exclusive-or.
// - Controller write completes in one edge; advance ignored then.
// - A detected write cycle releases the data outputs.
// - Sleep entry and exit take two cycles; host deselects first.
`timescale 1ns/1ps

module write_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [PW:0]      count_r, count_nxt;
   logic             push, pop;

   assign in_ready_out  = (count_r != (PW+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = mem_r[rd_ptr_r];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt  = count_r;
      if (push) begin
         wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

   // Storage needs no reset; count guards its contents
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end
endmodule : write_queue

module pipelined_burst_sram_port
   import burst_port_pkg::*;
#(
   parameter int AW = burst_port_pkg::ADDR_W
) (
   input  wire logic                        clock_in,
   input  wire logic                        rst_b_in,
   input  wire logic [AW-1:0]               addr_in,
   input  wire logic                        processor_addr_strobe_n_in,
   input  wire logic                        controller_addr_strobe_n_in,
   input  wire logic                        burst_advance_n_in,
   input  wire logic                        global_write_n_in,
   input  wire logic                        byte_write_qualify_n_in,
   input  wire logic [burst_port_pkg::LANES-1:0] byte_lane_select_n_in,
   input  wire logic                        chip_sel_one_n_in,
   input  wire logic                        chip_sel_two_in,
   input  wire logic                        chip_sel_three_n_in,
   input  wire logic                        out_enable_n_in,
   input  wire logic                        sleep_request_in,
   input  wire logic                        order_select_in,
   input  wire logic [burst_port_pkg::WORD_W-1:0] data_in,
   output logic      [burst_port_pkg::WORD_W-1:0] data_out,
   output logic                             data_oe_out,
   output logic                             write_ready_out
);
   import burst_port_pkg::*;
   localparam int QW = AW + LANES + WORD_W;

   function automatic logic [1:0] burst_low(input logic [1:0] first,
                                            input logic [1:0] cnt,
                                            input logic       interleave);
      burst_low = interleave ? (first ^ cnt) : 2'(first + cnt);
   endfunction : burst_low

   logic [WORD_W-1:0]  array_r [2**AW];
   port_state_e        state_r, state_nxt;
   logic [AW-1:0]      addr_r, addr_nxt;
   logic [1:0]         first_r, first_nxt, cnt_r, cnt_nxt;
   logic               rd_acc_r, rd_acc_nxt, wr_cyc_r, wr_cyc_nxt;
   logic               rd_valid_r, rd_valid_nxt, mask_r, mask_nxt;
   logic [WORD_W-1:0]  dout_r, dout_nxt;
   logic [1:0]         sleep_sync_r, oe_sync_r, order_sync_r;
   logic               order_r, order_taken_r;
   logic               sleep_on, cs_ok, proc_take, ctrl_take, strobe;
   logic               start, desel, cont, acc_write, acc_read;
   logic [LANES-1:0]   lane_mask;
   logic               wr_detect;
   logic [AW-1:0]      rd_addr, wr_addr;
   logic [QW-1:0]      q_in, q_out;
   logic               q_valid;

   // Asynchronous pins pass two flops; enable therefore lags two cycles
   always_ff @(posedge clock_in) begin
      // Strap sync runs through reset so it is settled at release
      order_sync_r  <= {order_sync_r[0], order_select_in};
      if (!rst_b_in) begin
         sleep_sync_r  <= '0;
         oe_sync_r     <= 2'h3;
         order_r       <= ORDER_RESET;
         order_taken_r <= 1'b0;
      end else begin
         sleep_sync_r  <= {sleep_sync_r[0], sleep_request_in};
         oe_sync_r     <= {oe_sync_r[0], out_enable_n_in};
         // Strap caught once after release; later changes are ignored
         if (!order_taken_r) begin
            order_r       <= order_sync_r[1];
            order_taken_r <= 1'b1;
         end
      end
   end
   assign sleep_on = sleep_sync_r[1];

   always_comb begin
      if (!global_write_n_in) begin
         lane_mask = '1;
      end else if (!byte_write_qualify_n_in) begin
         lane_mask = ~byte_lane_select_n_in;
      end else begin
         lane_mask = '0;
      end
   end
   assign wr_detect = (lane_mask != '0);

   assign cs_ok     = !chip_sel_one_n_in && chip_sel_two_in
                      && !chip_sel_three_n_in;
   assign proc_take = !processor_addr_strobe_n_in
                      && !chip_sel_one_n_in;
   assign ctrl_take = !controller_addr_strobe_n_in && !proc_take;
   assign strobe    = proc_take || ctrl_take;
   assign start     = !sleep_on && strobe && cs_ok;
   assign desel     = !sleep_on && strobe && !cs_ok;
   assign cont      = !sleep_on && !strobe && (state_r == ST_BURST);
   // Processor start is always a read; its write lands next edge
   assign acc_write = ((start && ctrl_take) || cont) && wr_detect;
   assign acc_read  = (start || cont) && !acc_write;

   always_comb begin
      state_nxt    = state_r;
      addr_nxt     = addr_r;
      first_nxt    = first_r;
      cnt_nxt      = cnt_r;
      rd_acc_nxt   = acc_read;
      wr_cyc_nxt   = acc_write;
      mask_nxt     = 1'b0;
      rd_valid_nxt = rd_acc_r && !desel && !sleep_on;
      dout_nxt     = rd_acc_r ? array_r[rd_addr] : dout_r;
      unique case (state_r)
         ST_IDLE, ST_BURST: begin
            if (sleep_on) begin
               state_nxt = ST_SLEEP;
            end else if (start) begin
               state_nxt = ST_BURST;
               addr_nxt  = addr_in;
               first_nxt = addr_in[1:0];
               cnt_nxt   = CNT_RESET;
               mask_nxt  = acc_read && (state_r == ST_IDLE);
            end else if (desel) begin
               state_nxt = ST_IDLE;
            end else if (cont && !burst_advance_n_in) begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ST_SLEEP: begin
            // Pending reads are dropped on entry; queued writes wait for exit
            if (!sleep_on) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   assign rd_addr = {addr_r[AW-1:2], burst_low(first_r, cnt_r, order_r)};
   assign wr_addr = {addr_nxt[AW-1:2],
                     burst_low(first_nxt, cnt_nxt, order_r)};
   assign q_in    = {wr_addr, lane_mask, data_in};

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         state_r    <= ST_IDLE;
         addr_r     <= '0;
         first_r    <= CNT_RESET;
         cnt_r      <= CNT_RESET;
         rd_acc_r   <= 1'b0;
         wr_cyc_r   <= 1'b0;
         rd_valid_r <= 1'b0;
         mask_r     <= 1'b0;
         dout_r     <= '0;
      end else begin
         state_r    <= state_nxt;
         addr_r     <= addr_nxt;
         first_r    <= first_nxt;
         cnt_r      <= cnt_nxt;
         rd_acc_r   <= rd_acc_nxt;
         wr_cyc_r   <= wr_cyc_nxt;
         rd_valid_r <= rd_valid_nxt;
         mask_r     <= mask_nxt;
         dout_r     <= dout_nxt;
      end
   end

   // Queue is drained every cycle except in sleep, when no writes arrive, so it holds one word at most
   write_queue #(
      .WIDTH (QW),
      .DEPTH (FIFO_DEPTH)
   ) u_queue (
      .clock_in      (clock_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (acc_write),
      .in_ready_out  (write_ready_out),
      .in_data_in    (q_in),
      .out_valid_out (q_valid),
      .out_ready_in  (!sleep_on),
      .out_data_out  (q_out)
   );

   // One process for all lanes: they share one array variable
   always_ff @(posedge clock_in) begin
      for (int l = 0; l < LANES; l++) begin
         if (q_valid && !sleep_on && q_out[WORD_W+l]) begin
            array_r[q_out[QW-1 -: AW]][l*LANE_W +: LANE_W]
               <= q_out[l*LANE_W +: LANE_W];
         end
      end
   end

   assign data_out    = dout_r;
   assign data_oe_out = rd_valid_r && !oe_sync_r[1] && !mask_r
                        && !wr_cyc_r && !sleep_on;

   a_addr_capture: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) start |=> addr_r == $past(addr_in))
      else $error("address not captured");
   a_burst_load: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) start |=> cnt_r == 2'h0 && first_r == $past(addr_in[1:0]))
      else $error("burst counter not loaded");
   a_burst_step: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) cont && !burst_advance_n_in
      |=> cnt_r == 2'($past(cnt_r) + 1'b1))
      else $error("burst counter did not step");
   a_proc_prio: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) !processor_addr_strobe_n_in && !chip_sel_one_n_in
      && cs_ok && !sleep_on |=> rd_acc_r && !wr_cyc_r)
      else $error("processor strobe not honoured as read");
   a_proc_ignore: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) chip_sel_one_n_in && controller_addr_strobe_n_in
      && state_r == ST_IDLE |=> state_r != ST_BURST)
      else $error("processor strobe taken with select one high");
   a_global_lanes: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) acc_write && !global_write_n_in
      |-> q_in[WORD_W +: LANES] == {LANES{1'b1}})
      else $error("global write missed a lane");
   a_read_latency: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) acc_read ##1 !desel && !sleep_on |=> rd_valid_r)
      else $error("read data not valid one edge later");
   a_deselect_off: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) desel |=> !data_oe_out)
      else $error("outputs driven after deselect");
   a_write_release: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) acc_write |=> !data_oe_out)
      else $error("outputs driven in write cycle");
   a_first_mask: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) start && acc_read && state_r == ST_IDLE
      |=> !data_oe_out)
      else $error("outputs driven in first cycle from deselect");
   a_sleep_quiet: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) $rose(sleep_sync_r[1]) |=> state_r == ST_SLEEP
      && !data_oe_out)
      else $error("sleep not entered");
   a_ctrl_single: assert property (@(posedge clock_in) disable iff
      (!rst_b_in) start && ctrl_take && wr_detect
      |=> wr_cyc_r && !rd_acc_r)
      else $error("controller write not taken in one edge");
endmodule : pipelined_burst_sram_port

// ---- common/burst_port_pkg.sv ----
// Purpose: shared constants for the pipelined burst memory port
// Assumes: one clock, synchronous active-low reset
// Notes:   array depth is kept small; the real part is far larger
package burst_port_pkg;
   localparam int          LANES        = 4;
   localparam int          LANE_W       = 9;
   localparam int          WORD_W       = LANES * LANE_W;
   localparam int          ADDR_W       = 10;
   localparam int          BURST_W      = 2;
   localparam int          FIFO_DEPTH   = 8;
   localparam logic        ORDER_RESET  = 1'b1;
   localparam logic [1:0]  CNT_RESET    = 2'h0;
   localparam int          SLEEP_CYCLES = 2;
   typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_SLEEP} port_state_e;
endpackage : burst_port_pkg

// ---- sim/burst_host.sv ----
// Purpose: bus master model driving the burst memory port
// Assumes: each request starts 1 ns after a rising edge
// Notes:   released write data flips, so a stale value never matches
`timescale 1ns/1ps
module burst_host (
   input  wire logic                              clock_in,
   output logic [burst_port_pkg::ADDR_W-1:0]      addr_out,
   output logic                                   processor_addr_strobe_n_out,
   output logic                                   controller_addr_strobe_n_out,
   output logic                                   burst_advance_n_out,
   output logic                                   global_write_n_out,
   output logic                                   byte_write_qualify_n_out,
   output logic [burst_port_pkg::LANES-1:0]       byte_lane_select_n_out,
   output logic                                   chip_sel_one_n_out,
   output logic                                   chip_sel_two_out,
   output logic                                   chip_sel_three_n_out,
   output logic [burst_port_pkg::WORD_W-1:0]      data_out
);
   import burst_port_pkg::*;
   logic [7:0] ctl;
   assign {processor_addr_strobe_n_out, controller_addr_strobe_n_out,
           burst_advance_n_out, global_write_n_out,
           byte_write_qualify_n_out, chip_sel_one_n_out,
           chip_sel_two_out, chip_sel_three_n_out} = ctl;
   // Held unchanged through the sampling edge
   task automatic acc(input logic [7:0] c, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] d, input logic [LANES-1:0] ln);
      ctl = c;
      addr_out = a;
      data_out = d;
      byte_lane_select_n_out = ln;
      @(posedge clock_in);
      #1;
   endtask : acc
   task automatic idle();
      ctl = 8'hFA;
      data_out = ~data_out;
      byte_lane_select_n_out = 4'hF;
   endtask : idle
   initial begin
      addr_out = '0;
      data_out = '0;
      idle();
   end
endmodule : burst_host

// ---- sim/test_pipelined_burst_sram_port.sv ----
// Purpose: self-checking bench for the burst memory port and its queue
// Assumes: inputs change 1 ns after a rising edge
// Notes:   burst order strap is only changed under reset
`timescale 1ns/1ps
module test_pipelined_burst_sram_port;
   import burst_port_pkg::*;
   localparam logic [7:0] RD = 8'h7A, WG = 8'hAA, NX = 8'hDA, DS = 8'hA8;
   logic clock_in, rst_b_in, out_enable_n_in, sleep_request_in;
   logic order_select_in, processor_addr_strobe_n_in;
   logic controller_addr_strobe_n_in, burst_advance_n_in;
   logic global_write_n_in, byte_write_qualify_n_in;
   logic chip_sel_one_n_in, chip_sel_two_in, chip_sel_three_n_in;
   logic data_oe_out, write_ready_out;
   logic [ADDR_W-1:0] addr_in;
   logic [LANES-1:0]  byte_lane_select_n_in;
   logic [WORD_W-1:0] data_in, data_out;
   int                failures = 0;
   int                n_tests = 0;
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   pipelined_burst_sram_port #(.AW(ADDR_W)) i_dut (.clock_in, .rst_b_in,
      .addr_in, .processor_addr_strobe_n_in, .controller_addr_strobe_n_in,
      .burst_advance_n_in, .global_write_n_in, .byte_write_qualify_n_in,
      .byte_lane_select_n_in, .chip_sel_one_n_in, .chip_sel_two_in,
      .chip_sel_three_n_in, .out_enable_n_in, .sleep_request_in,
      .order_select_in, .data_in, .data_out, .data_oe_out, .write_ready_out);
   burst_host i_host (.clock_in, .addr_out(addr_in),
      .processor_addr_strobe_n_out(processor_addr_strobe_n_in),
      .controller_addr_strobe_n_out(controller_addr_strobe_n_in),
      .burst_advance_n_out(burst_advance_n_in),
      .global_write_n_out(global_write_n_in),
      .byte_write_qualify_n_out(byte_write_qualify_n_in),
      .byte_lane_select_n_out(byte_lane_select_n_in),
      .chip_sel_one_n_out(chip_sel_one_n_in),
      .chip_sel_two_out(chip_sel_two_in),
      .chip_sel_three_n_out(chip_sel_three_n_in), .data_out(data_in));
   function automatic logic [WORD_W-1:0] pat(input int a);
      return {LANES{LANE_W'(a * 37 + 5)}};
   endfunction : pat
   task automatic check(input string what, input logic [WORD_W-1:0] seen,
                        input logic [WORD_W-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic tick();
      @(posedge clock_in);
      #1;
   endtask : tick
   task automatic do_reset(input logic s);
      rst_b_in = 1'b0;
      order_select_in = s;
      repeat (8) tick();
      rst_b_in = 1'b1;
      repeat (3) tick();
   endtask : do_reset
   // Write lands well before the next access reads it
   task automatic wr(input logic [7:0] c, input int a,
                     input logic [WORD_W-1:0] d, input logic [3:0] ln);
      i_host.acc(c, ADDR_W'(a), d, ln);
      i_host.idle();
      repeat (3) tick();
   endtask : wr
   task automatic rd(input int a, input logic [WORD_W-1:0] exp);
      i_host.acc(RD, ADDR_W'(a), '0, 4'hF);
      i_host.idle();
      tick();
      check("read data", data_out, exp);
   endtask : rd
   task automatic t_access();
      for (int a = 8; a < 12; a++) wr(8'h8A, a, pat(a), 4'hF);
      rd(9, pat(9));
      wr(8'hB2, 10, ~pat(10), 4'hA);
      rd(10, pat(10) ^ {9'h0, 9'h1FF, 9'h0, 9'h1FF});
      wr(WG, 20, pat(20), 4'hF);
      i_host.acc(8'h6A, ADDR_W'(20), ~pat(20), 4'h0);
      wr(8'hF2, 20, 36'h123456789, 4'hE);
      rd(20, (pat(20) & ~36'h1FF) | 36'h189);
      wr(WG, 21, pat(21), 4'hF);
      wr(8'h2A, 21, ~pat(21), 4'hF);
      rd(21, pat(21));
      wr(8'h2E, 21, ~pat(21), 4'hF);
      wr(DS, 21, ~pat(21), 4'hF);
      rd(21, pat(21));
   endtask : t_access
   task automatic t_pipe();
      i_host.acc(DS, '0, '0, 4'hF);
      i_host.acc(RD, ADDR_W'(8), '0, 4'hF);
      check("first enable", data_oe_out, 1'b0);
      i_host.acc(RD, ADDR_W'(9), '0, 4'hF);
      check("first data", data_out, pat(8));
      i_host.acc(RD, ADDR_W'(11), '0, 4'hF);
      check("second enable", data_oe_out, 1'b1);
      i_host.acc(WG, ADDR_W'(12), pat(12), 4'hF);
      check("write enable", data_oe_out, 1'b0);
      check("third data", data_out, pat(11));
      i_host.acc(RD, ADDR_W'(8), '0, 4'hF);
      i_host.acc(RD, ADDR_W'(9), '0, 4'hF);
      i_host.acc(DS, '0, '0, 4'hF);
      check("deselect enable", data_oe_out, 1'b0);
      i_host.idle();
      out_enable_n_in = 1'b1;
      repeat (4) tick();
      i_host.acc(RD, ADDR_W'(8), '0, 4'hF);
      i_host.acc(RD, ADDR_W'(9), '0, 4'hF);
      i_host.acc(RD, ADDR_W'(11), '0, 4'hF);
      check("released data", data_out, pat(9));
      check("released enable", data_oe_out, 1'b0);
      i_host.idle();
      out_enable_n_in = 1'b0;
      repeat (4) tick();
   endtask : t_pipe
   task automatic t_sleep();
      wr(WG, 30, pat(30), 4'hF);
      wr(DS, 0, '0, 4'hF);
      sleep_request_in = 1'b1;
      repeat (6) tick();
      wr(WG, 30, ~pat(30), 4'hF);
      sleep_request_in = 1'b0;
      repeat (6) tick();
      rd(30, pat(30));
   endtask : t_sleep
   task automatic t_burst(input logic s, input int f);
      int e;
      do_reset(s);
      for (int a = 0; a < 4; a++) wr(WG, a, pat(a), 4'hF);
      i_host.acc(RD, ADDR_W'(f), '0, 4'hF);
      for (int i = 0; i < 4; i++) begin
         e = s ? (f ^ i) : ((f + i) % 4);
         if (i < 3) i_host.acc(NX, '0, '0, 4'hF);
         else begin
            i_host.idle();
            tick();
         end
         check("burst data", data_out, pat(e));
      end
   endtask : t_burst
   // Writes on consecutive edges stream through the queue, then read back
   task automatic t_queue();
      for (int a = 40; a < 48; a++) begin
         i_host.acc(WG, ADDR_W'(a), pat(a), 4'hF);
         check("queue ready", 36'(write_ready_out), 36'h1);
      end
      i_host.idle();
      repeat (3) tick();
      check("queue drained", 36'(write_ready_out), 36'h1);
      for (int a = 40; a < 48; a++) begin
         i_host.acc(RD, ADDR_W'(a), '0, 4'hF);
         if (a > 40) check("queue order", data_out, pat(a - 1));
      end
      i_host.idle();
      tick();
      check("queue last", data_out, pat(47));
   endtask : t_queue
   initial begin
      out_enable_n_in = 1'b0;
      sleep_request_in = 1'b0;
      do_reset(1'b1);
      t_access();
      t_pipe();
      t_sleep();
      t_burst(1'b0, 3);
      t_burst(1'b1, 1);
      t_queue();
      finish_test();
   end
   initial begin
      #1_000_000;
      failures++;
      finish_test();
   end
endmodule : test_pipelined_burst_sram_port
